//--- hw/switch_frame_admission_control.sv
// Notes on behaviour
// [RULE_01] With the multicast exclusion bit set multicast is not metered, clear it is.
// [RULE_02] Back pressure uses carrier sense when its mode bit is one, else collisions.
// [RULE_03] In fair mode a non-flow-controlled port sharing a busy egress may be dropped.
// [RULE_04] Without fair mode only the flow-controlled port is paused, nothing dropped.
// [RULE_05] Sixteen or more collisions drop the frame unless dropping is disabled.
// [RULE_06] Software disabling collision drop should also enable alternate back-off.
// [RULE_07] Jumbo mode accepts up to the programmed limit capped at 9000 and wins.
// [RULE_08] With the size check off and no jumbo, frames up to 2000 bytes pass.
// [RULE_09] With the size check on, tagged over 1522 and untagged over 1518 drop.
// [RULE_10] Pass-short lets frames from 32 to 64 bytes through.
// [RULE_11] Without pass-short any frame under 64 bytes is dropped.
// [RULE_12] Null VID replacement puts the port default VID in place of a zero VID.
// [RULE_13] The storm rate is eleven bits, high three and low eight from two registers.
// [RULE_14] The per-period byte budget is the storm rate times 64.
// [RULE_15] The period is 5 ms at 1000, 50 ms at 100 and 500 ms at 10 Mbps.
// [RULE_16] Alternate back-off only ever acts on half-duplex ports.
// [RULE_17] Metered frames past the budget drop, and the count restarts each period.
`timescale 1ns/10ps
`include "frame_admission_consts.svh"
module switch_frame_admission_control
    import frame_admission_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `STORM_TICK_US * `REF_CLK_MHZ
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // avalon-mm slave, byte addresses
    input  wire logic [13:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // received frame descriptor
    input  wire logic        frame_valid_i,
    input  wire logic [13:0] frame_len_i,
    input  wire logic        frame_tagged_i,
    input  wire logic        frame_bcast_i,
    input  wire logic        frame_mcast_i,
    input  wire logic [11:0] frame_vid_i,
    input  wire logic [11:0] port_default_vid_i,
    input  wire logic [13:0] jumbo_limit_i,
    input  wire link_speed_t link_speed_i,
    output logic             verdict_valid_o,
    output logic             accept_o,
    output logic             drop_size_o,
    output logic             drop_storm_o,
    output logic [11:0]      vid_o,
    // transmit collision handling
    input  wire logic        tx_attempt_i,
    input  wire logic [4:0]  tx_collision_count_i,
    output logic             tx_discard_o,
    output logic             tx_retry_o,
    // back pressure and flow control
    input  wire logic        half_duplex_i,
    input  wire logic        bp_request_i,
    input  wire logic        alt_backoff_req_i,
    input  wire logic        egress_contend_i,
    input  wire logic        ingress_is_fc_i,
    output logic             bp_carrier_o,
    output logic             bp_collision_o,
    output logic             backoff_alt_o,
    output logic             fc_pause_o,
    output logic             nonfc_drop_o
);

    bus_state_t  bus_state_r;
    logic [7:0]  admission_r;
    logic [7:0]  storm_high_r;
    logic [7:0]  storm_low_r;
    logic [10:0] storm_rate;
    logic        bus_req;
    logic        bus_done;
    logic [13:0] max_len;
    logic        size_ok;
    logic        metered;
    logic        over_budget;

    // word-aligned hit test shared by the read and write paths
    function automatic logic reg_hit(input logic [13:0] addr,
                                     input logic [11:0] idx);
        return addr == {idx, 2'h0};
    endfunction

    assign bus_req  = avs_read_i || avs_write_i;
    assign bus_done = (bus_state_r == BUS_ACK);
    // one wait state lets read data come from a flip-flop
    assign avs_waitrequest_o = bus_req && !bus_done;

    // handshake: idle takes the request, ack completes it
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            case (bus_state_r)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_r <= BUS_ACK;
                    end
                end
                BUS_ACK:  bus_state_r <= BUS_IDLE;
                default:  bus_state_r <= BUS_IDLE;
            endcase
        end
    end

    // read data captured in the wait cycle; unmapped words read zero
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (avs_read_i && !bus_done) begin
            if (reg_hit(avs_address_i, `REG_IDX_ADMISSION)) begin
                avs_readdata_o <= {24'h000000, admission_r};
            end else if (reg_hit(avs_address_i, `REG_IDX_STORM_HIGH)) begin
                avs_readdata_o <= {24'h000000, storm_high_r};
            end else if (reg_hit(avs_address_i, `REG_IDX_STORM_LOW)) begin
                avs_readdata_o <= {24'h000000, storm_low_r};
            end else begin
                avs_readdata_o <= 32'h00000000;
            end
        end
    end

    // writes land on the completing edge, low byte lane only
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            admission_r  <= `RST_ADMISSION;
            storm_high_r <= `RST_STORM_HIGH;
            storm_low_r  <= `RST_STORM_LOW;
        end else if (avs_write_i && bus_done && avs_byteenable_i[0]) begin
            if (reg_hit(avs_address_i, `REG_IDX_ADMISSION)) begin
                admission_r <= avs_writedata_i[7:0];
            end else if (reg_hit(avs_address_i, `REG_IDX_STORM_HIGH)) begin
                storm_high_r <= avs_writedata_i[7:0];
            end else if (reg_hit(avs_address_i, `REG_IDX_STORM_LOW)) begin
                storm_low_r <= avs_writedata_i[7:0];
            end
        end
    end

    assign storm_rate = {storm_high_r[`STORM_HIGH_MSB:0], storm_low_r}; // [RULE_13]

    // upper size limit; jumbo takes precedence over the check-off bit
    always_comb begin
        if (admission_r[`BIT_JUMBO_EN]) begin
            max_len = (jumbo_limit_i > `LEN_JUMBO_CAP) ?
                      `LEN_JUMBO_CAP : jumbo_limit_i; // [RULE_07]
        end else if (admission_r[`BIT_MAX_CHECK_OFF]) begin
            max_len = `LEN_NOCHECK_MAX; // [RULE_08]
        end else if (frame_tagged_i) begin
            max_len = `LEN_TAGGED_MAX; // [RULE_09]
        end else begin
            max_len = `LEN_UNTAGGED_MAX; // [RULE_09]
        end
    end

    // runts under 32 bytes never pass, even with pass-short
    assign size_ok = (frame_len_i <= max_len) &&
        (admission_r[`BIT_PASS_SHORT] ? (frame_len_i >= `LEN_RUNT_MIN) // [RULE_10]
                                      : (frame_len_i >= `LEN_STD_MIN)); // [RULE_11]

    // only frames that survive the size check consume storm budget
    assign metered = frame_valid_i && size_ok && (frame_bcast_i ||
        (frame_mcast_i && !admission_r[`BIT_MCAST_EXCL])); // [RULE_01]

    storm_meter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_storm_meter (
        .ref_clk_i     (ref_clk_i),
        .reset_n_i     (reset_n_i),
        .meter_req_i   (metered),
        .meter_len_i   (frame_len_i),
        .storm_rate_i  (storm_rate),
        .link_speed_i  (link_speed_i),
        .over_budget_o (over_budget),
        .period_end_o  ()
    );

    // verdict one cycle after the descriptor
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            verdict_valid_o <= 1'b0;
            accept_o        <= 1'b0;
            drop_size_o     <= 1'b0;
            drop_storm_o    <= 1'b0;
        end else begin
            verdict_valid_o <= frame_valid_i;
            accept_o        <= frame_valid_i && size_ok &&
                               !(metered && over_budget);
            drop_size_o     <= frame_valid_i && !size_ok;
            drop_storm_o    <= metered && over_budget; // [RULE_17]
        end
    end

    // vid out, zero vid replaced when enabled
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vid_o <= 12'h000;
        end else if (frame_valid_i) begin
            if (storm_high_r[`BIT_NULL_VID_REPL] && frame_vid_i == 12'h000) begin
                vid_o <= port_default_vid_i; // [RULE_12]
            end else begin
                vid_o <= frame_vid_i; // [RULE_12]
            end
        end
    end

    // excessive collision verdict per transmit attempt
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_discard_o <= 1'b0;
            tx_retry_o   <= 1'b0;
        end else begin
            tx_discard_o <= tx_attempt_i && !admission_r[`BIT_NO_COLL_DROP] &&
                            (tx_collision_count_i >= `COLL_LIMIT); // [RULE_05]
            tx_retry_o   <= tx_attempt_i && (admission_r[`BIT_NO_COLL_DROP] ||
                            (tx_collision_count_i < `COLL_LIMIT)); // [RULE_05]
        end
    end

    // back pressure style and fair mode contention handling
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bp_carrier_o   <= 1'b0;
            bp_collision_o <= 1'b0;
            backoff_alt_o  <= 1'b0;
            fc_pause_o     <= 1'b0;
            nonfc_drop_o   <= 1'b0;
        end else begin
            bp_carrier_o   <= bp_request_i && half_duplex_i &&
                              admission_r[`BIT_BP_CARRIER]; // [RULE_02]
            bp_collision_o <= bp_request_i && half_duplex_i &&
                              !admission_r[`BIT_BP_CARRIER]; // [RULE_02]
            // full-duplex ports never see the alternate back-off
            backoff_alt_o  <= alt_backoff_req_i && half_duplex_i; // [RULE_16]
            fc_pause_o     <= egress_contend_i && ingress_is_fc_i; // [RULE_04]
            nonfc_drop_o   <= egress_contend_i && !ingress_is_fc_i &&
                              admission_r[`BIT_FAIR_MODE]; // [RULE_03]
        end
    end

    property p_mcast_excl;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        frame_valid_i && frame_mcast_i && !frame_bcast_i &&
            admission_r[`BIT_MCAST_EXCL] |=> !drop_storm_o;
    endproperty
    a_mcast_excl: assert property (p_mcast_excl) // [RULE_01]
        else $error("excluded multicast was storm dropped");

    property p_bp_style;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        bp_request_i && half_duplex_i |=>
            (bp_carrier_o == $past(admission_r[`BIT_BP_CARRIER])) &&
            (bp_collision_o != bp_carrier_o);
    endproperty
    a_bp_style: assert property (p_bp_style) // [RULE_02]
        else $error("back pressure style mismatch");

    property p_fair_drop;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        egress_contend_i && !ingress_is_fc_i && admission_r[`BIT_FAIR_MODE]
            |=> nonfc_drop_o && !fc_pause_o;
    endproperty
    a_fair_drop: assert property (p_fair_drop) // [RULE_03]
        else $error("fair mode did not drop non-flow-controlled traffic");

    property p_unfair;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        egress_contend_i && !admission_r[`BIT_FAIR_MODE]
            |=> !nonfc_drop_o && (fc_pause_o == $past(ingress_is_fc_i));
    endproperty
    a_unfair: assert property (p_unfair) // [RULE_04]
        else $error("non-fair mode dropped or paused wrongly");

    property p_coll_drop;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        tx_attempt_i && tx_collision_count_i >= `COLL_LIMIT
            |=> tx_discard_o != $past(admission_r[`BIT_NO_COLL_DROP]);
    endproperty
    a_coll_drop: assert property (p_coll_drop) // [RULE_05]
        else $error("excessive collision verdict wrong");

    property p_jumbo;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        frame_valid_i && admission_r[`BIT_JUMBO_EN] &&
            frame_len_i > `LEN_JUMBO_CAP |=> drop_size_o;
    endproperty
    a_jumbo: assert property (p_jumbo) // [RULE_07]
        else $error("jumbo frame over cap accepted");

    property p_nocheck;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        frame_valid_i && !admission_r[`BIT_JUMBO_EN] &&
            admission_r[`BIT_MAX_CHECK_OFF] && frame_len_i >= `LEN_STD_MIN
            |=> drop_size_o == ($past(frame_len_i) > `LEN_NOCHECK_MAX);
    endproperty
    a_nocheck: assert property (p_nocheck) // [RULE_08]
        else $error("2000 byte limit misapplied");

    property p_std_max;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        frame_valid_i && admission_r[2:1] == 2'h0 && frame_tagged_i &&
            frame_len_i > `LEN_TAGGED_MAX |=> drop_size_o && !accept_o;
    endproperty
    a_std_max: assert property (p_std_max) // [RULE_09]
        else $error("oversize tagged frame accepted");

    property p_short;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        frame_valid_i && frame_len_i < `LEN_STD_MIN &&
            !admission_r[`BIT_PASS_SHORT] |=> drop_size_o;
    endproperty
    a_short: assert property (p_short) // [RULE_11]
        else $error("short frame accepted without pass-short");

    property p_null_vid;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        frame_valid_i && frame_vid_i == 12'h000 &&
            storm_high_r[`BIT_NULL_VID_REPL]
            |=> vid_o == $past(port_default_vid_i);
    endproperty
    a_null_vid: assert property (p_null_vid) // [RULE_12]
        else $error("null vid not replaced");

    property p_bus_wait;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        bus_req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("bus request stalled more than one cycle");

endmodule

//--- hw/frame_admission_consts.svh
`ifndef FRAME_ADMISSION_CONSTS_SVH
`define FRAME_ADMISSION_CONSTS_SVH

// register indices; byte address is four times the index
`define REG_IDX_ADMISSION      12'h331
`define REG_IDX_STORM_HIGH     12'h332
`define REG_IDX_STORM_LOW      12'h333

// reset values
`define RST_ADMISSION          8'hF0
`define RST_STORM_HIGH         8'h00
`define RST_STORM_LOW          8'h4A

// admission control bit positions
`define BIT_MCAST_EXCL         6
`define BIT_BP_CARRIER         5
`define BIT_FAIR_MODE          4
`define BIT_NO_COLL_DROP       3
`define BIT_JUMBO_EN           2
`define BIT_MAX_CHECK_OFF      1
`define BIT_PASS_SHORT         0
// vid and storm high bit positions
`define BIT_NULL_VID_REPL      3
`define STORM_HIGH_MSB         2

// frame size limits in bytes, collision limit and storm unit shift
`define LEN_RUNT_MIN           14'h0020
`define LEN_STD_MIN            14'h0040
`define LEN_UNTAGGED_MAX       14'h05EE
`define LEN_TAGGED_MAX         14'h05F2
`define LEN_NOCHECK_MAX        14'h07D0
`define LEN_JUMBO_CAP          14'h2328
`define COLL_LIMIT             5'h10
`define STORM_UNIT_SHIFT       6

// timing
`define REF_CLK_MHZ            25
`define STORM_TICK_US          5000
`define PERIOD_1000_MS         5
`define PERIOD_100_MS          50
`define PERIOD_10_MS           500

`endif

//--- hw/frame_admission_pkg.sv
package frame_admission_pkg;

    typedef enum logic [1:0] {
        SPEED_10   = 2'h0,
        SPEED_100  = 2'h1,
        SPEED_1000 = 2'h2
    } link_speed_t;

    // one-hot bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK  = 2'h2
    } bus_state_t;

endpackage

//--- hw/storm_meter.sv
`timescale 1ns/10ps
`include "frame_admission_consts.svh"
module storm_meter
    import frame_admission_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `STORM_TICK_US * `REF_CLK_MHZ
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        meter_req_i,
    input  wire logic [13:0] meter_len_i,
    input  wire logic [10:0] storm_rate_i,
    input  wire link_speed_t link_speed_i,
    output logic             over_budget_o,
    output logic             period_end_o
);

    localparam logic [6:0] TICKS_1000 =
        7'((`PERIOD_1000_MS * 1000) / `STORM_TICK_US);
    localparam logic [6:0] TICKS_100 =
        7'((`PERIOD_100_MS * 1000) / `STORM_TICK_US);
    localparam logic [6:0] TICKS_10 =
        7'((`PERIOD_10_MS * 1000) / `STORM_TICK_US);
    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

    logic [23:0] div_r;
    logic        tick;
    logic [6:0]  tick_num_r;
    logic [6:0]  tick_limit;
    logic [16:0] budget;
    logic [16:0] accum_r;
    logic [17:0] sum;

    // divider gives a one-cycle enable every 5 ms
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= 24'h000000;
        end else if (tick) begin
            div_r <= 24'h000000;
        end else begin
            div_r <= div_r + 24'h000001;
        end
    end
    assign tick = (div_r == TICK_LAST);

    // period length follows the port speed
    always_comb begin
        case (link_speed_i)
            SPEED_1000: tick_limit = TICKS_1000; // [RULE_15]
            SPEED_100:  tick_limit = TICKS_100;  // [RULE_15]
            default:    tick_limit = TICKS_10;   // [RULE_15]
        endcase
    end

    // a speed change mid-period simply ends it at the new length or later
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_num_r <= 7'h00;
        end else if (period_end_o) begin
            tick_num_r <= 7'h00;
        end else if (tick) begin
            tick_num_r <= tick_num_r + 7'h01;
        end
    end
    assign period_end_o = tick && (tick_num_r + 7'h01 >= tick_limit);

    assign budget = {storm_rate_i, 6'h00}; // [RULE_14]
    assign sum = {1'b0, accum_r} + {4'h0, meter_len_i};
    assign over_budget_o = (sum > {1'b0, budget}); // [RULE_17]

    // a frame at the boundary is charged to the fresh period
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            accum_r <= 17'h00000;
        end else if (period_end_o) begin
            if (meter_req_i && ({3'h0, meter_len_i} <= budget)) begin
                accum_r <= {3'h0, meter_len_i}; // [RULE_17]
            end else begin
                accum_r <= 17'h00000; // [RULE_17]
            end
        end else if (meter_req_i && !over_budget_o) begin
            accum_r <= sum[16:0]; // [RULE_14]
        end
    end

    property p_no_charge_when_over;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        meter_req_i && over_budget_o && !period_end_o
            |=> accum_r == $past(accum_r);
    endproperty
    a_no_charge_when_over: assert property (p_no_charge_when_over) // [RULE_17]
        else $error("over-budget frame was charged");

    property p_period_restart;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        period_end_o && !meter_req_i |=> accum_r == 17'h00000;
    endproperty
    a_period_restart: assert property (p_period_restart) // [RULE_17]
        else $error("byte count not restarted at period end");

    property p_period_len;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        period_end_o |-> (tick_num_r + 7'h01 == tick_limit) && tick;
    endproperty
    a_period_len: assert property (p_period_len) // [RULE_15]
        else $error("period ended at wrong tick count");

endmodule

//--- tb/link_partner_model.sv
`timescale 1ns/10ps
// behavioural link partner: turns bench requests into frame descriptors
module link_partner_model (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        go_i,
    input  wire logic [13:0] len_i,
    input  wire logic [2:0]  kind_i,
    input  wire logic [11:0] vid_i,
    output logic             valid_o,
    output logic [13:0]      len_o,
    output logic [2:0]       kind_o,
    output logic [11:0]      vid_o
);
    // fields are stale between frames, so scramble them rather than hold
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valid_o <= 1'b0;
            len_o   <= 14'h0000;
            kind_o  <= 3'h0;
            vid_o   <= 12'h000;
        end else begin
            valid_o <= go_i;
            len_o   <= go_i ? len_i : ~len_o;
            kind_o  <= go_i ? kind_i : ~kind_o;
            vid_o   <= go_i ? vid_i : ~vid_o;
        end
    end
endmodule

//--- tb/switch_frame_admission_control_tb.sv
`timescale 1ns/10ps
module switch_frame_admission_control_tb;
    import frame_admission_pkg::*;
    localparam logic [13:0] a_adm = 14'h0CC4;
    localparam logic [13:0] a_hi  = 14'h0CC8;
    localparam logic [13:0] a_lo  = 14'h0CCC;
    localparam logic [2:0]  ok    = 3'h4;
    localparam logic [2:0]  sz    = 3'h2;
    localparam logic [2:0]  st    = 3'h1;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [13:0] addr  = 14'h0000;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [3:0]  be    = 4'h0;
    logic [31:0] wd    = 32'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic        go    = 1'b0;
    logic [13:0] len   = 14'h0000;
    logic [2:0]  kind  = 3'h0;
    logic [11:0] vid   = 12'h000;
    logic [13:0] jl    = 14'h2328;
    logic        txa   = 1'b0;
    logic [4:0]  txc   = 5'h00;
    logic [4:0]  li    = 5'h00;
    link_speed_t spd   = SPEED_1000;
    logic        fv, vv, acc, dsz, dst, txd, txr;
    logic [13:0] fl;
    logic [2:0]  fk;
    logic [11:0] fvid, vo;
    wire  [4:0]  lo;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    always #20 clk = ~clk;

    link_partner_model link_partner_model_inst (
        .ref_clk_i(clk), .reset_n_i(rst_n), .go_i(go), .len_i(len),
        .kind_i(kind), .vid_i(vid), .valid_o(fv), .len_o(fl),
        .kind_o(fk), .vid_o(fvid));

    switch_frame_admission_control #(.TICK_CYCLES(400))
        switch_frame_admission_control_inst (
        .ref_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
        .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .frame_valid_i(fv), .frame_len_i(fl),
        .frame_tagged_i(fk[2]), .frame_bcast_i(fk[1]),
        .frame_mcast_i(fk[0]), .frame_vid_i(fvid),
        .port_default_vid_i(12'h5A5), .jumbo_limit_i(jl),
        .link_speed_i(spd), .verdict_valid_o(vv),
        .accept_o(acc), .drop_size_o(dsz), .drop_storm_o(dst),
        .vid_o(vo), .tx_attempt_i(txa), .tx_collision_count_i(txc),
        .tx_discard_o(txd), .tx_retry_o(txr), .half_duplex_i(li[4]),
        .bp_request_i(li[3]), .alt_backoff_req_i(li[2]),
        .egress_contend_i(li[1]), .ingress_is_fc_i(li[0]),
        .bp_carrier_o(lo[4]), .bp_collision_o(lo[3]),
        .backoff_alt_o(lo[2]), .fc_pause_o(lo[1]), .nonfc_drop_o(lo[0]));

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [13:0] a,
                       input logic [7:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wd <= {24'h0, d};
        be <= b;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wrr(input logic [13:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rdc(input logic [13:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hF, q);
        cmp(q, {24'h0, e});
    endtask

    // one descriptor; verdict comes a fixed cycle after the partner
    task automatic frm(input logic [13:0] l, input logic [2:0] k,
                       input logic [11:0] v, input logic [2:0] e,
                       input logic [11:0] ev);
        @(posedge clk);
        go <= 1'b1;
        len <= l;
        kind <= k;
        vid <= v;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (vv !== 1'b1)
            @(negedge clk);
        cmp(32'({acc, dsz, dst}), 32'(e));
        cmp(32'(vo), 32'(ev));
    endtask

    task automatic fs(input logic [13:0] l, input logic [2:0] k,
                      input logic [2:0] e);
        frm(l, k, 12'h001, e, 12'h001);
    endtask

    task automatic tx(input logic [4:0] c, input logic [1:0] e);
        @(posedge clk);
        txa <= 1'b1;
        txc <= c;
        @(posedge clk);
        txa <= 1'b0;
        @(negedge clk);
        cmp(32'({txd, txr}), 32'(e));
    endtask

    task automatic lv(input logic [4:0] i, input logic [4:0] e);
        @(posedge clk);
        li <= i;
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp(32'(lo), 32'(e));
    endtask

    // hang guard well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        logic [31:0] q;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(a_adm, 8'hF0);
        rdc(a_hi, 8'h00);
        rdc(a_lo, 8'h4A);
        bus(1'b1, a_lo, 8'h55, 4'h0, q);
        rdc(a_lo, 8'h4A);
        rdc(14'h0CD0, 8'h00);
        wrr(a_hi, 8'hF7);
        rdc(a_hi, 8'hF7);
        wrr(a_hi, 8'h07);
        wrr(a_lo, 8'hFF);
        wrr(a_adm, 8'h00);
        fs(14'h05EE, 3'h0, ok);
        fs(14'h05EF, 3'h0, sz);
        fs(14'h05F2, 3'h4, ok);
        fs(14'h05F3, 3'h4, sz);
        fs(14'h003F, 3'h0, sz);
        fs(14'h0040, 3'h0, ok);
        wrr(a_adm, 8'h01);
        fs(14'h0020, 3'h0, ok);
        fs(14'h001F, 3'h0, sz);
        wrr(a_adm, 8'h02);
        fs(14'h07D0, 3'h0, ok);
        fs(14'h07D1, 3'h0, sz);
        wrr(a_adm, 8'h06);
        fs(14'h2328, 3'h0, ok);
        fs(14'h2329, 3'h0, sz);
        @(posedge clk);
        jl <= 14'h0BB8;
        fs(14'h0BB9, 3'h0, sz);
        wrr(a_hi, 8'h08);
        frm(14'h0040, 3'h0, 12'h000, ok, 12'h5A5);
        frm(14'h0040, 3'h0, 12'h003, ok, 12'h003);
        wrr(a_hi, 8'h00);
        frm(14'h0040, 3'h0, 12'h000, ok, 12'h000);
        wrr(a_lo, 8'h01);
        wrr(a_adm, 8'h40);
        fs(14'h0040, 3'h2, ok);
        fs(14'h0040, 3'h2, st);
        fs(14'h0040, 3'h1, ok);
        wrr(a_adm, 8'h00);
        fs(14'h0040, 3'h1, st);
        repeat (450) @(posedge clk);
        fs(14'h0040, 3'h2, ok);
        tx(5'h10, 2'b10);
        // collision drop disabled alone; the alternate back-off request is driven after the retry check
        wrr(a_adm, 8'h08);
        tx(5'h10, 2'b01);
        lv(5'b10100, 5'b00100);
        wrr(a_adm, 8'h30);
        lv(5'b11010, 5'b10001);
        wrr(a_adm, 8'h00);
        lv(5'b11111, 5'b01110);
        wrr(a_adm, 8'h10);
        lv(5'b00110, 5'b00001);
        // at 100 Mbps one tick no longer ends the period, ten ticks do
        @(posedge clk);
        spd <= SPEED_100;
        repeat (450) @(posedge clk);
        fs(14'h0040, 3'h2, st);
        repeat (3600) @(posedge clk);
        fs(14'h0040, 3'h2, ok);
        print_verdict();
    end
endmodule
